// ---- dsw_builder.sv ----
// Drive status word builder: assembles the 16-bit status word from condition flags.
// Assumes the command word and telegram strobe come from same-clock fieldbus logic,
// and that condition flags come from other domains and are synchronised here.
`timescale 1ns/100ps
module dsw_builder (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Fieldbus side, same clock
	input wire logic [15:0] master_command_word,
	input wire logic telegram_strobe,
	output logic [15:0] drive_status_word,
	output logic [15:0] live_status_word,
	// Configuration
	input wire logic profile_select,
	// Drive conditions, asynchronous levels
	input wire logic control_ready,
	input wire logic power_stage_ok,
	input wire logic start_signals_ok,
	input wire logic fault_active,
	input wire logic warning_any,
	input wire logic speed_at_ref,
	input wire logic local_panel_stop,
	input wire logic local_site_sel,
	input wire logic freq_in_window,
	input wire logic start_present,
	input wire logic freq_above_zero,
	input wire logic overload_halt,
	input wire logic dc_link_bad,
	input wire logic torque_over_limit,
	input wire logic thermal_over
);
	typedef struct packed {
		logic [15:0] cmd;
		logic trip;
		logic inhibit;
		logic prev_reset;
		logic prev_coast_n;
		logic prev_fast_n;
		logic prev_on;
		logic [15:0] live;
		logic [15:0] word;
	} dsw_state_t;

	dsw_state_t st_q;
	dsw_state_t st_d;
	// One synchroniser per level; levels are unrelated, so no word coherency needed
	logic c_ctrl_rdy;
	logic c_pwr_ok;
	logic c_start_ok;
	logic c_fault;
	logic c_warn;
	logic c_speed;
	logic c_panel_stop;
	logic c_local_site;
	logic c_freq_win;
	logic c_start;
	logic c_freq_nz;
	logic c_ovl;
	logic c_dc_bad;
	logic c_torque;
	logic c_thermal;

	dsw_sync #(
		.WIDTH(1)
	) u_sync_ctrl_rdy (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(control_ready),
		.sync_out(c_ctrl_rdy)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_pwr_ok (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(power_stage_ok),
		.sync_out(c_pwr_ok)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_start_ok (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(start_signals_ok),
		.sync_out(c_start_ok)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_fault (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(fault_active),
		.sync_out(c_fault)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_warn (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(warning_any),
		.sync_out(c_warn)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_speed (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(speed_at_ref),
		.sync_out(c_speed)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_panel_stop (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(local_panel_stop),
		.sync_out(c_panel_stop)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_local_site (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(local_site_sel),
		.sync_out(c_local_site)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_freq_win (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(freq_in_window),
		.sync_out(c_freq_win)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_start (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(start_present),
		.sync_out(c_start)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_freq_nz (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(freq_above_zero),
		.sync_out(c_freq_nz)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_ovl (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(overload_halt),
		.sync_out(c_ovl)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_dc_bad (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(dc_link_bad),
		.sync_out(c_dc_bad)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_torque (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(torque_over_limit),
		.sync_out(c_torque)
	);

	dsw_sync #(
		.WIDTH(1)
	) u_sync_thermal (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.async_in(thermal_over),
		.sync_out(c_thermal)
	);

	always_comb begin
		logic on_c;
		logic coast_n_c;
		logic fast_n_c;
		logic all_on;
		logic reset_rise;
		logic set_inhibit;
		logic clr_inhibit;
		logic [15:0] w;
		on_c = 1'b0;
		coast_n_c = 1'b0;
		fast_n_c = 1'b0;
		all_on = 1'b0;
		reset_rise = 1'b0;
		set_inhibit = 1'b0;
		clr_inhibit = 1'b0;
		w = '0;
		st_d = st_q;

		if (master_command_word[dsw_pkg::CB_DATA_VALID]) begin
			st_d.cmd = master_command_word;
		end

		on_c = st_d.cmd[dsw_pkg::CB_ON];
		coast_n_c = st_d.cmd[dsw_pkg::CB_COAST_N];
		fast_n_c = st_d.cmd[dsw_pkg::CB_FAST_N];
		all_on = on_c & coast_n_c & fast_n_c;
		reset_rise = st_d.cmd[dsw_pkg::CB_FAULT_RESET] & ~st_q.prev_reset;

		if (c_fault) begin
			st_d.trip = 1'b1;
		end else if (reset_rise) begin
			st_d.trip = 1'b0;
		end

		set_inhibit = (st_q.prev_on & ~on_c)
			| (st_q.prev_coast_n & ~coast_n_c)
			| (st_q.prev_fast_n & ~fast_n_c);
		// Inhibit clear pattern; set wins
		// Only a word valid now; the stored word would undo a later set
		clr_inhibit = master_command_word[dsw_pkg::CB_DATA_VALID] & ~on_c & coast_n_c & fast_n_c;
		if (profile_select && set_inhibit) begin
			st_d.inhibit = 1'b1;
		end else if (clr_inhibit) begin
			st_d.inhibit = 1'b0;
		end

		st_d.prev_reset = st_d.cmd[dsw_pkg::CB_FAULT_RESET];
		st_d.prev_on = on_c;
		st_d.prev_coast_n = coast_n_c;
		st_d.prev_fast_n = fast_n_c;

		w[dsw_pkg::SB_CTRL_READY] = c_ctrl_rdy & all_on & ~st_d.trip;
		w[dsw_pkg::SB_DRIVE_READY] = c_ctrl_rdy & all_on & ~st_d.trip & c_pwr_ok & c_start_ok;
		w[dsw_pkg::SB_ENABLE] = all_on & ~st_d.trip;
		w[dsw_pkg::SB_TRIP] = st_d.trip;
		w[dsw_pkg::SB_COAST_ECHO] = coast_n_c;
		w[dsw_pkg::SB_FAST_ECHO] = fast_n_c;
		w[dsw_pkg::SB_START_INHIBIT] = st_d.inhibit;
		w[dsw_pkg::SB_WARNING] = c_warn;
		w[dsw_pkg::SB_SPEED_MATCH] = c_speed;
		w[dsw_pkg::SB_BUS_CONTROL] = ~c_panel_stop & ~c_local_site;
		w[dsw_pkg::SB_FREQ_OK] = c_freq_win;
		w[dsw_pkg::SB_RUNNING] = c_start | c_freq_nz;
		w[dsw_pkg::SB_AUTO_RESTART] = c_ovl & ~st_d.trip;
		w[dsw_pkg::SB_VOLT_LIMIT] = c_dc_bad;
		w[dsw_pkg::SB_TORQUE_LIMIT] = c_torque;
		w[dsw_pkg::SB_TIMER_LIMIT] = c_thermal;

		// Live every cycle, frozen per telegram
		st_d.live = w;
		if (telegram_strobe) begin
			st_d.word = w;
		end
	end

	// Power-up counts as an inhibit event
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q.cmd <= dsw_pkg::CMD_RESET;
			st_q.trip <= dsw_pkg::DSW_RESET[dsw_pkg::SB_TRIP];
			st_q.inhibit <= dsw_pkg::DSW_RESET[dsw_pkg::SB_START_INHIBIT];
			st_q.prev_reset <= dsw_pkg::CMD_RESET[dsw_pkg::CB_FAULT_RESET];
			st_q.prev_coast_n <= dsw_pkg::CMD_RESET[dsw_pkg::CB_COAST_N];
			st_q.prev_fast_n <= dsw_pkg::CMD_RESET[dsw_pkg::CB_FAST_N];
			st_q.prev_on <= dsw_pkg::CMD_RESET[dsw_pkg::CB_ON];
			st_q.live <= dsw_pkg::DSW_RESET;
			st_q.word <= dsw_pkg::DSW_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign drive_status_word = st_q.word;
	assign live_status_word = st_q.live;
endmodule : dsw_builder

// ---- dsw_builder_properties.sv ----
// Port checker for the status word builder.
// Bound onto dsw_builder; single clock domain.
`timescale 1ns/100ps
module dsw_builder_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Watched ports
	input wire logic [15:0] master_command_word,
	input wire logic telegram_strobe,
	input wire logic [15:0] drive_status_word,
	input wire logic [15:0] live_status_word
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_c1; master_command_word[10] |=> live_status_word[4] == $past(master_command_word[1]); endproperty
	a_c1: assert property (p_c1) else $error("coast echo wrong");
	property p_c2; master_command_word[10] |=> live_status_word[5] == $past(master_command_word[2]); endproperty
	a_c2: assert property (p_c2) else $error("fast echo wrong");
	property p_inv; !master_command_word[10] |=> $stable(live_status_word[5:4]); endproperty
	a_inv: assert property (p_inv) else $error("invalid word used");
	property p_tel; telegram_strobe |=> drive_status_word == live_status_word; endproperty
	a_tel: assert property (p_tel) else $error("telegram word wrong");
	property p_hold; !telegram_strobe |=> $stable(drive_status_word); endproperty
	a_hold: assert property (p_hold) else $error("word moved off telegram");
	property p_en; live_status_word[2] |-> live_status_word[5:3] == 3'b110; endproperty
	a_en: assert property (p_en) else $error("enable wrong");
	property p_rdy; live_status_word[0] |-> live_status_word[5:3] == 3'b110; endproperty
	a_rdy: assert property (p_rdy) else $error("ready wrong");
	property p_drv; live_status_word[1] |-> live_status_word[0]; endproperty
	a_drv: assert property (p_drv) else $error("drive ready wrong");
	property p_clr; $fell(live_status_word[6]) |-> $past(master_command_word[10:0] & 11'h407) == 11'h406; endproperty
	a_clr: assert property (p_clr) else $error("inhibit cleared wrongly");
	property p_trip; $fell(live_status_word[3]) |-> $past(master_command_word[10] & master_command_word[7]); endproperty
	a_trip: assert property (p_trip) else $error("trip cleared without reset command");
	property p_auto; live_status_word[12] |-> !live_status_word[3]; endproperty
	a_auto: assert property (p_auto) else $error("auto restart shown while tripped");
endmodule : dsw_builder_properties

bind dsw_builder dsw_builder_properties i_dsw_builder_properties (.clk_sys, .nrst, .master_command_word,
	.telegram_strobe, .drive_status_word, .live_status_word);

// ---- dsw_builder_tb.sv ----
// Bench for the status word builder.
// Master model drives the command side; conditions driven here.
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
	$display("Error %s exp %h got %h", n, e, a); end end
module dsw_builder_tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic profile_select = 1'b1;
	logic [14:0] c = 15'h0000;
	logic [15:0] cw;
	logic ts;
	logic [15:0] dsw;
	logic [15:0] live;
	logic [8:0] e;
	int err_count = 0;
	int comparisons = 0;
	always #10 clk_sys = ~clk_sys;
	dsw_master_model i_dsw_master_model (.clk_sys(clk_sys), .master_command_word(cw), .telegram_strobe(ts));
	dsw_builder i_dsw_builder (.clk_sys(clk_sys), .nrst(nrst), .master_command_word(cw), .telegram_strobe(ts),
		.drive_status_word(dsw), .live_status_word(live), .profile_select(profile_select),
		.control_ready(c[0]), .power_stage_ok(c[1]), .start_signals_ok(c[2]), .fault_active(c[3]),
		.warning_any(c[4]), .speed_at_ref(c[5]), .local_panel_stop(c[6]), .local_site_sel(c[7]),
		.freq_in_window(c[8]), .start_present(c[9]), .freq_above_zero(c[10]), .overload_halt(c[11]),
		.dc_link_bad(c[12]), .torque_over_limit(c[13]), .thermal_over(c[14]));
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : results
	task wt;
		repeat (4) @(negedge clk_sys);
	endtask : wt
	initial begin
		#200us;
		err_count++;
		results();
	end
	initial begin
		repeat (5) @(negedge clk_sys);
		`CHK("reset live", 16'h0040, live)
		`CHK("reset word", 16'h0040, dsw)
		nrst = 1'b1;
		@(negedge clk_sys);
		i_dsw_master_model.xfer(16'h0406, 1'b0);
		`CHK("inhibit", 3'b011, live[6:4])
		c[2:0] = 3'b111;
		i_dsw_master_model.xfer(16'h0407, 1'b0);
		wt();
		`CHK("ready", 3'b111, live[2:0])
		c[1] = 1'b0;
		wt();
		`CHK("no power", 2'b01, live[1:0])
		c[1] = 1'b1;
		wt();
		i_dsw_master_model.xfer(16'h0000, 1'b0);
		`CHK("ignored", 3'b011, live[6:4])
		i_dsw_master_model.xfer(16'h0405, 1'b1);
		`CHK("coast", 4'b1100, {live[6:4], live[0]})
		`CHK("telegram", 16'h0260, dsw)
		$display("test commands done");
		c[3] = 1'b1;
		i_dsw_master_model.xfer(16'h0407, 1'b0);
		wt();
		`CHK("trip", 2'b10, live[3:2])
		c[3] = 1'b0;
		wt();
		`CHK("trip held", 1'b1, live[3])
		`CHK("word held", 16'h0260, dsw)
		i_dsw_master_model.xfer(16'h0487, 1'b1);
		wt();
		`CHK("trip reset", 2'b01, live[3:2])
		`CHK("telegram after reset", 16'h0277, dsw)
		$display("test trip done");
		for (int i = 4; i < 15; i++) begin
			c = 15'h0001 << i;
			wt();
			e = {c[14:11], c[10] | c[9], c[8], !(c[6] | c[7]), c[5:4]};
			`CHK("conditions", e, live[15:7])
		end
		$display("test conditions done");
		i_dsw_master_model.xfer(16'h0406, 1'b0);
		`CHK("stop ack", 1'b1, live[6])
		wt();
		`CHK("inhibit clear", 1'b0, live[6])
		i_dsw_master_model.xfer(16'h0407, 1'b0);
		profile_select = 1'b0;
		i_dsw_master_model.xfer(16'h0405, 1'b0);
		`CHK("no profile", 1'b0, live[6])
		profile_select = 1'b1;
		i_dsw_master_model.xfer(16'h0407, 1'b0);
		i_dsw_master_model.xfer(16'h0403, 1'b0);
		`CHK("fast stop", 3'b101, live[6:4])
		i_dsw_master_model.xfer(16'h0006, 1'b0);
		wt();
		`CHK("refused clear", 3'b101, live[6:4])
		$display("test inhibit done");
		results();
	end
endmodule : dsw_builder_tb

// ---- dsw_master_model.sv ----
// Fieldbus master model: command word and telegram pulse.
// Drives at the falling edge of clk_sys.
`timescale 1ns/100ps
module dsw_master_model (
	// Clock
	input wire logic clk_sys,
	// Telegram
	output logic [15:0] master_command_word,
	output logic telegram_strobe
);
	initial begin
		master_command_word = 16'h0000;
		telegram_strobe = 1'b0;
	end
	// Word held; valid bit from caller
	// Strobe lasts one edge, then an idle cycle so calls never re-raise it at once
	task xfer(input logic [15:0] w, input logic s);
		master_command_word = w;
		if (s) begin
			telegram_strobe = 1'b1;
			@(negedge clk_sys);
			telegram_strobe = 1'b0;
		end
		@(negedge clk_sys);
	endtask : xfer
endmodule : dsw_master_model

// ---- dsw_pkg.sv ----
// Package for the drive status word builder: bit positions and reset values.
// Assumes a single system clock domain; used by the builder only, its input stage (dsw_sync) does not reference it.
package dsw_pkg;
	localparam int unsigned DSW_WIDTH = 16;
	// Status word bit positions
	localparam int unsigned SB_CTRL_READY = 0;
	localparam int unsigned SB_DRIVE_READY = 1;
	localparam int unsigned SB_ENABLE = 2;
	localparam int unsigned SB_TRIP = 3;
	localparam int unsigned SB_COAST_ECHO = 4;
	localparam int unsigned SB_FAST_ECHO = 5;
	localparam int unsigned SB_START_INHIBIT = 6;
	localparam int unsigned SB_WARNING = 7;
	localparam int unsigned SB_SPEED_MATCH = 8;
	localparam int unsigned SB_BUS_CONTROL = 9;
	localparam int unsigned SB_FREQ_OK = 10;
	localparam int unsigned SB_RUNNING = 11;
	localparam int unsigned SB_AUTO_RESTART = 12;
	localparam int unsigned SB_VOLT_LIMIT = 13;
	localparam int unsigned SB_TORQUE_LIMIT = 14;
	localparam int unsigned SB_TIMER_LIMIT = 15;
	// Command word bit positions
	localparam int unsigned CB_ON = 0;
	localparam int unsigned CB_COAST_N = 1;
	localparam int unsigned CB_FAST_N = 2;
	localparam int unsigned CB_FAULT_RESET = 7;
	localparam int unsigned CB_DATA_VALID = 10;
	// Reset values
	localparam logic [15:0] DSW_RESET = 16'h0040;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam int unsigned COND_WIDTH = 15;
	localparam logic [14:0] COND_RESET = 15'h0000;
	// Input synchroniser depth
	localparam int unsigned SYNC_STAGES = 2;
endpackage : dsw_pkg

// ---- dsw_sync.sv ----
// Two flip-flop synchroniser for a bundle of levels from outside the clock domain.
// Assumes levels are stable for several cycles; no bus coherency across bits.
`timescale 1ns/100ps
module dsw_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} dsw_sync_t;

	dsw_sync_t st_q;
	dsw_sync_t st_d;

	if (WIDTH < 1) begin : g_width_check
		$error("dsw_sync: WIDTH must be at least 1");
	end

	// First stage feeds only the second
	always_comb begin
		st_d = st_q;
		st_d.meta = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;
endmodule : dsw_sync
